// File: match_based_pwm_unit.sv
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module match_based_pwm_unit #(
   parameter int W = 32,
   parameter int NM = 7,
   parameter int NO = NM - 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire pwm_pkg::apb_req_s apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic [NO:1] pwm_out
);
   pwm_pkg::ctrl_s ctrl_q;
   logic [W-1:0] tc_q;
   logic [W-1:0] pc_q;
   logic [W-1:0] pr_q;
   logic [`MCTL_W*NM-1:0] mctl_q;
   logic [NM-1:0] status_q;
   logic [NM-1:0] mask_q;
   logic [NM-1:0] latch_q;
   logic [NO:2] dbl_q;
   logic [NO:1] oe_q;
   logic [NO:1] lvl_q;
   logic [31:0] rdata_q;
   logic err_q;
   logic [W-1:0] shadow_q [NM];
   logic [W-1:0] active_q [NM];
   logic [NM-1:0] hit;
   logic [NM-1:0] hit_rst;
   logic [NM-1:0] hit_stop;
   logic [NM-1:0] hit_irq;
   logic tick;
   logic any_rst;
   logic any_stop;
   logic cyc_rst;
   logic wr;
   logic rd_setup;
   logic in_m;
   logic [7:0] mofs;
   logic [2:0] midx;
   logic [31:0] rdata_d;
   logic err_d;

   // Bus strobes and match window decode
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_setup = apb_req.psel & ~apb_req.penable;
   assign in_m = (apb_req.paddr >= `OFF_MATCH0)
      && (apb_req.paddr <= `OFF_MATCH_LAST)
      && (apb_req.paddr[1:0] == 2'h0);
   assign mofs = apb_req.paddr - `OFF_MATCH0;
   assign midx = mofs[4:2];
   assign pready = 1'b1;
   assign prdata = rdata_q;
   assign pslverr = err_q;

   // Prescale wrap strobe
   assign tick = ctrl_q.cnt_en & ~ctrl_q.cnt_rst & (pc_q == pr_q);
   assign any_rst = |hit_rst;
   assign any_stop = |hit_stop;
   assign cyc_rst = hit_rst[0];

   // Per match compare, shadow and active value
   genvar k;
   generate
      for (k = 0; k < NM; k++)
      begin : g_match
         logic sel_k;
         assign sel_k = in_m && (midx == 3'(k));
         assign hit[k] = tick & (tc_q == active_q[k]);
         // Cycle match always resets in PWM mode
         if (k == 0)
         begin : g_cyc
            assign hit_rst[k] = hit[k]
               & (mctl_q[`MCTL_RST] | ctrl_q.pwm_en);
         end
         else
         begin : g_oth
            assign hit_rst[k] = hit[k]
               & mctl_q[`MCTL_W*k+`MCTL_RST];
         end
         assign hit_stop[k] = hit[k] & mctl_q[`MCTL_W*k+`MCTL_STOP];
         assign hit_irq[k] = hit[k] & mctl_q[`MCTL_W*k+`MCTL_IRQ];

         // Software copy of the match value
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               shadow_q[k] <= W'(`RST_ZERO);
            else if (wr && sel_k)
               shadow_q[k] <= W'(apb_req.pwdata);
         end

         // Compared value: direct in timer mode, released in PWM mode
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               active_q[k] <= W'(`RST_ZERO);
            else if (!ctrl_q.pwm_en && wr && sel_k)
               active_q[k] <= W'(apb_req.pwdata);
            else if (ctrl_q.pwm_en && cyc_rst && latch_q[k])
               active_q[k] <= shadow_q[k];
         end
      end
   endgenerate

   // Control register; a stop match beats a software write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= '0;
      else
      begin
         if (wr && apb_req.paddr == `OFF_CTRL)
         begin
            ctrl_q.cnt_en <= apb_req.pwdata[`CTRL_EN];
            ctrl_q.cnt_rst <= apb_req.pwdata[`CTRL_RST];
            ctrl_q.pwm_en <= apb_req.pwdata[`CTRL_PWM];
         end
         if (any_stop)
            ctrl_q.cnt_en <= 1'b0;
      end
   end

   // Prescale counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pc_q <= W'(`RST_ZERO);
      else if (ctrl_q.cnt_rst || tick)
         pc_q <= W'(`RST_ZERO);
      else if (ctrl_q.cnt_en)
         pc_q <= pc_q + W'(1);
   end

   // Main counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tc_q <= W'(`RST_ZERO);
      else if (ctrl_q.cnt_rst)
         tc_q <= W'(`RST_ZERO);
      else if (wr && apb_req.paddr == `OFF_COUNT)
         tc_q <= W'(apb_req.pwdata);
      else if (any_rst)
         tc_q <= W'(`RST_ZERO);
      else if (tick)
         tc_q <= tc_q + W'(1);
   end

   // Prescale limit, match actions, PWM control, mask
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pr_q <= W'(`RST_ZERO);
         mctl_q <= '0;
         dbl_q <= '0;
         oe_q <= '0;
         mask_q <= '0;
      end
      else if (wr)
      begin
         if (apb_req.paddr == `OFF_PRESC)
            pr_q <= W'(apb_req.pwdata);
         if (apb_req.paddr == `OFF_MCTL)
            mctl_q <= apb_req.pwdata[`MCTL_W*NM-1:0];
         if (apb_req.paddr == `OFF_PWMCTL)
         begin
            dbl_q <= apb_req.pwdata[NO:2];
            oe_q <= apb_req.pwdata[`PWMCTL_OE+NO:`PWMCTL_OE+1];
         end
         if (apb_req.paddr == `OFF_MASK)
            mask_q <= apb_req.pwdata[NM-1:0];
      end
   end

   // Release bits; a fresh release beats the clear at cycle end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         latch_q <= '0;
      else if (wr && apb_req.paddr == `OFF_RELEASE)
         latch_q <= latch_q | apb_req.pwdata[NM-1:0];
      else if (ctrl_q.pwm_en && cyc_rst)
         latch_q <= '0;
   end

   // Sticky match flags, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_q <= '0;
      else if (wr && apb_req.paddr == `OFF_STATUS)
         status_q <= (status_q & ~apb_req.pwdata[NM-1:0]) | hit_irq;
      else
         status_q <= status_q | hit_irq;
   end

   assign irq = |(status_q & mask_q);

   // Output levels; fall wins over rise, single edge outputs rise on the cycle match
   genvar n;
   generate
      for (n = 1; n <= NO; n++)
      begin : g_out
         logic set_n;
         if (n == 1)
         begin : g_single
            assign set_n = hit[0];
         end
         else
         begin : g_sel
            assign set_n = dbl_q[n] ? hit[n-1] : hit[0];
         end
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               lvl_q[n] <= 1'b0;
            else if (!ctrl_q.pwm_en)
               lvl_q[n] <= 1'b0;
            else if (hit[n])
               lvl_q[n] <= 1'b0;
            else if (set_n)
               lvl_q[n] <= 1'b1;
         end
      end
   endgenerate

   // Only PWM levels reach pins
   assign pwm_out = lvl_q & oe_q;

   // Read mux, sampled in the setup cycle
   always_comb
   begin
      rdata_d = 32'h0;
      err_d = 1'b0;
      if (in_m)
         rdata_d = 32'(shadow_q[midx]);
      else
      begin
         unique case (apb_req.paddr)
            `OFF_STATUS: rdata_d = 32'(status_q);
            `OFF_CTRL: rdata_d = {28'h0, ctrl_q.pwm_en, 1'b0,
               ctrl_q.cnt_rst, ctrl_q.cnt_en};
            `OFF_COUNT: rdata_d = 32'(tc_q);
            `OFF_PRESC: rdata_d = 32'(pr_q);
            `OFF_PCNT: rdata_d = 32'(pc_q);
            `OFF_MCTL: rdata_d = 32'(mctl_q);
            `OFF_PWMCTL: rdata_d = 32'({oe_q, 2'h0, dbl_q, 2'h0});
            `OFF_RELEASE: rdata_d = 32'(latch_q);
            `OFF_MASK: rdata_d = 32'(mask_q);
            default: err_d = 1'b1;
         endcase
      end
   end

   // Registered read data and error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata_q <= `RST_ZERO;
         err_q <= 1'b0;
      end
      else if (rd_setup)
      begin
         rdata_q <= apb_req.pwrite ? 32'h0 : rdata_d;
         err_q <= err_d;
      end
   end

   property p_presc_wrap;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q.cnt_en && !ctrl_q.cnt_rst && pc_q == pr_q)
      |=> pc_q == W'(0);
   endproperty
   a_presc_wrap: assert property (p_presc_wrap)
      else $error("prescaler did not wrap");

   property p_tc_step;
      @(posedge pclk) disable iff (!presetn)
      (tick && !any_rst && !ctrl_q.cnt_rst && !wr)
      |=> tc_q == $past(tc_q) + W'(1);
   endproperty
   a_tc_step: assert property (p_tc_step)
      else $error("counter did not step on prescale wrap");

   property p_cycle_rst;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q.pwm_en && hit[0] && !wr) |=> tc_q == W'(0);
   endproperty
   a_cycle_rst: assert property (p_cycle_rst)
      else $error("cycle match did not reset counter");

   property p_rise;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q.pwm_en && hit[0] && !hit[1]) |=> lvl_q[1];
   endproperty
   a_rise: assert property (p_rise)
      else $error("single edge output missed rising edge");

   property p_fall_wins;
      @(posedge pclk) disable iff (!presetn)
      (hit[0] && hit[1]) |=> !lvl_q[1];
   endproperty
   a_fall_wins: assert property (p_fall_wins)
      else $error("coinciding edges did not resolve low");

   property p_const_low;
      @(posedge pclk) disable iff (!presetn)
      (!lvl_q[1] && active_q[1] == active_q[0]) |=> !lvl_q[1];
   endproperty
   a_const_low: assert property (p_const_low)
      else $error("constant low output rose");

   property p_dbl;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q.pwm_en && dbl_q[2] && hit[1] && !hit[2])
      |=> lvl_q[2] ##1 (lvl_q[2] || $past(hit[2]) || !ctrl_q.pwm_en);
   endproperty
   a_dbl: assert property (p_dbl)
      else $error("double edge output missed rising match");

   property p_timer_mode;
      @(posedge pclk) disable iff (!presetn)
      !ctrl_q.pwm_en |=> lvl_q == '0;
   endproperty
   a_timer_mode: assert property (p_timer_mode)
      else $error("waveform driven in timer mode");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q.pwm_en && !latch_q[1]) |=> $stable(active_q[1]);
   endproperty
   a_hold: assert property (p_hold)
      else $error("unreleased match value took effect");

   property p_apply;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q.pwm_en && cyc_rst && latch_q[1])
      |=> active_q[1] == $past(shadow_q[1]);
   endproperty
   a_apply: assert property (p_apply)
      else $error("released value not loaded at cycle end");

   property p_stop;
      @(posedge pclk) disable iff (!presetn)
      any_stop |=> !ctrl_q.cnt_en
         ##1 ($stable(tc_q) || $past(wr) || $past(ctrl_q.cnt_rst));
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop match did not halt counter");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      (|(hit_irq & mask_q)) |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("masked-in match did not raise interrupt");
endmodule

// File: pwm_cfg.svh
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
// Register byte offsets
`define OFF_STATUS 8'h00
`define OFF_CTRL 8'h04
`define OFF_COUNT 8'h08
`define OFF_PRESC 8'h0C
`define OFF_PCNT 8'h10
`define OFF_MCTL 8'h14
`define OFF_MATCH0 8'h18
`define OFF_MATCH_LAST 8'h30
`define OFF_PWMCTL 8'h34
`define OFF_RELEASE 8'h38
`define OFF_MASK 8'h3C
// Control register bits
`define CTRL_EN 0
`define CTRL_RST 1
`define CTRL_PWM 3
// Match control: three bits per match register
`define MCTL_W 3
`define MCTL_IRQ 0
`define MCTL_RST 1
`define MCTL_STOP 2
// PWM control: enable of output n sits at this bit plus n
`define PWMCTL_OE 8
// Reset values
`define RST_ZERO 32'h0
`endif

// File: pwm_pkg.sv
package pwm_pkg;
   typedef struct packed {
      logic pwm_en;
      logic cnt_rst;
      logic cnt_en;
   } ctrl_s;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;
endpackage

// File: test_match_based_pwm_unit.sv
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module test_match_based_pwm_unit;
   logic pclk;
   logic presetn;
   pwm_pkg::apb_req_s apb_req;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [6:1] pwm_out;
   int fail_count;
   int checks_done;
   int seed;
   logic [31:0] rd;
   logic err;
   int m0;
   int p;
   int t;
   int h;
   int a;
   int b;
   int w [1:6];

   // Compare and count
   `define CHK(got, exp, msg) \
      begin \
         checks_done++; \
         if ((got) !== (exp)) \
         begin \
            fail_count++; \
            $display("wrong value at %0t: %s", $time, msg); \
         end \
      end

   match_based_pwm_unit u_dut (
      .pclk(pclk),
      .presetn(presetn),
      .apb_req(apb_req),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .irq(irq),
      .pwm_out(pwm_out)
   );

   // Free running clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One APB transfer, idle cycle first
   task automatic apb(input logic wr, input logic [7:0] ad,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= wr;
      apb_req.paddr <= ad;
      apb_req.pwdata <= d;
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         fail_count++;
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   // Release shadows, then let two cycles pass
   task automatic rel(input logic [31:0] m);
      apb(1'b1, `OFF_RELEASE, m);
      repeat (2 * m0 + 2) @(posedge pclk);
   endtask

   // High cycles of a double edge output
   function automatic int dbl_hi(input int ra, input int fa, input int m);
      return (fa > ra) ? fa - ra : m + 1 - (ra - fa);
   endfunction

   // Measure one high and one low phase of output n
   task automatic meas(input int n, input int ehi, input int elo);
      int c;
      int l;
      c = 0;
      h = 0;
      l = 0;
      if (ehi == 0)
      begin
         repeat (3 * m0) @(posedge pclk) h += (pwm_out[n] !== 1'b0);
         `CHK(h, 0, "constant low output pulsed")
         return;
      end
      while (pwm_out[n] !== 1'b0 && c < 99) @(posedge pclk) c++;
      while (pwm_out[n] !== 1'b1 && c < 99) @(posedge pclk) c++;
      while (pwm_out[n] === 1'b1 && h < 99) @(posedge pclk) h++;
      while (pwm_out[n] === 1'b0 && l < 99) @(posedge pclk) l++;
      if (c >= 99 || h >= 99 || l >= 99)
      begin
         fail_count++;
         wrap_up();
      end
      `CHK(h, ehi, "pulse width")
      `CHK(h + l, m0 + 1, "pulse period")
   endtask

   // Main sequence
   initial
   begin
      seed = 32'h4d19;
      fail_count = 0;
      checks_done = 0;
      presetn = 1'b0;
      apb_req = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, unmapped place, read-only count
      for (int ad = 0; ad <= 'h3C; ad += 4)
      begin
         apb(1'b0, 8'(ad), 32'h0);
         `CHK(rd, `RST_ZERO, "reset value")
         `CHK(err, 1'b0, "mapped read flagged")
      end
      apb(1'b0, 8'h40, 32'h0);
      `CHK(err, 1'b1, "unmapped read not flagged")
      apb(1'b1, `OFF_PCNT, 32'h5);
      apb(1'b0, `OFF_PCNT, 32'h0);
      `CHK(rd, 32'h0, "prescale count written")
      $display("test reset done");

      // Timer mode: stop with interrupt, timed through the prescaler
      p = $unsigned($random(seed)) % 4;
      apb(1'b1, `OFF_PRESC, p);
      apb(1'b1, `OFF_MATCH0 + 8'h4, 32'h5);
      apb(1'b1, `OFF_MCTL, 32'h28);
      apb(1'b1, `OFF_MASK, 32'h2);
      apb(1'b1, `OFF_CTRL, 32'h1);
      t = 0;
      while (irq !== 1'b1 && t < 200) @(posedge pclk) t++;
      `CHK(t >= 5 * (p + 1) && t <= 6 * (p + 1) + 3, 1'b1, "stop time")
      apb(1'b0, `OFF_CTRL, 32'h0);
      `CHK(rd[`CTRL_EN], 1'b0, "stop match kept counting")
      apb(1'b0, `OFF_STATUS, 32'h0);
      `CHK(rd[6:0], 7'h02, "match flag")
      apb(1'b1, `OFF_MASK, 32'h0);
      #1 `CHK(irq, 1'b0, "masked irq")
      apb(1'b1, `OFF_MASK, 32'h2);
      #1 `CHK(irq, 1'b1, "unmasked irq")
      apb(1'b1, `OFF_STATUS, 32'h2);
      #1 `CHK(irq, 1'b0, "irq after clear")
      $display("test timer stop done");

      // Timer mode: reset action, no waveforms
      apb(1'b1, `OFF_PRESC, 32'h0);
      apb(1'b1, `OFF_MATCH0 + 8'h8, 32'h3);
      apb(1'b1, `OFF_MCTL, 32'h80);
      apb(1'b1, `OFF_PWMCTL, 32'h7E00);
      apb(1'b1, `OFF_CTRL, 32'h2);
      apb(1'b1, `OFF_CTRL, 32'h1);
      h = 0;
      repeat (6)
      begin
         apb(1'b0, `OFF_COUNT, 32'h0);
         h += (rd > 32'h3);
         h += (pwm_out !== 6'h00);
      end
      `CHK(h, 0, "timer reset or outputs off")
      $display("test timer reset done");

      // PWM single edge on all six outputs, last one constant low
      m0 = 4 + $unsigned($random(seed)) % 6;
      apb(1'b1, `OFF_CTRL, 32'h2);
      apb(1'b1, `OFF_MCTL, 32'h0);
      apb(1'b1, `OFF_MATCH0, m0);
      for (int n = 1; n <= 6; n++)
      begin
         w[n] = (n == 6) ? m0 : 1 + $unsigned($random(seed)) % (m0 - 1);
         apb(1'b1, `OFF_MATCH0 + 8'(4 * n), w[n]);
      end
      apb(1'b1, `OFF_CTRL, 32'h9);
      rel(32'h7F);
      for (int n = 1; n <= 6; n++)
         meas(n, (w[n] == m0) ? 0 : w[n] + 1, 0);
      // Unreleased value must wait
      a = (w[1] == m0 - 1) ? m0 - 2 : m0 - 1;
      apb(1'b1, `OFF_MATCH0 + 8'h4, a);
      apb(1'b0, `OFF_MATCH0 + 8'h4, 32'h0);
      `CHK(rd, 32'(a), "shadow readback")
      meas(1, w[1] + 1, 0);
      rel(32'h02);
      meas(1, a + 1, 0);
      $display("test single edge done");

      // Double edge on output 2, positive then negative pulse
      apb(1'b1, `OFF_PWMCTL, 32'h7E04);
      for (int i = 0; i < 2; i++)
      begin
         a = i ? m0 - 1 : 1;
         b = i ? 1 : m0 - 1;
         apb(1'b1, `OFF_MATCH0 + 8'h4, a);
         apb(1'b1, `OFF_MATCH0 + 8'h8, b);
         rel(32'h06);
         meas(2, dbl_hi(a, b, m0), 0);
      end
      $display("test double edge done");

      // Leaving PWM mode silences the outputs
      apb(1'b1, `OFF_CTRL, 32'h1);
      h = 0;
      // Levels clear one edge after the mode change lands
      @(posedge pclk);
      repeat (2 * m0) @(posedge pclk) h += (pwm_out !== 6'h00);
      `CHK(h, 0, "outputs in timer mode")
      $display("test pwm off done");
      wrap_up();
   end
endmodule
